// ===== rtl/wsn_pkg.sv
// constants, types and command codes for the wiper shift and nonvolatile store block
// What this block does
// - A 6 dB up shift turns a zero wiper code into one and doubles a nonzero code below midscale.
// - A 6 dB up shift of a code at or above midscale saturates it to full scale 1023.
// - A 6 dB down shift moves the 10-bit code one place right, dropping bit 0 and filling zero.
// - The down shift truncates odd codes and never rounds, keeping the half-step error.
// - Store address 0 holds the saved channel 1 code, 1 the channel 2 code, 15 the tolerance.
// - Store addresses 2 to 14 each hold one 16-bit user word, thirteen in all.
// - User words are written by the store-user-data command and read back by the read-store command.
// - Saved codes load the wiper registers at power-on, on restore, on restore-all and on a preset pulse.
// - A restore leaves the read-mode power state set until a no-operation command clears it.
// - The tolerance word is set at the factory and is read-only to the host.
// - The tolerance word is sign-magnitude: bit 15 sign, bits 14:8 integer, bits 7:0 fraction.
package wsn_pkg;

  localparam int unsigned CODE_W = 10;
  localparam int unsigned WORD_W = 16;
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DEPTH  = 16;
  localparam int unsigned NCH    = 2;

  localparam logic [CODE_W-1:0] CODE_ZERO = 10'h000;
  localparam logic [CODE_W-1:0] CODE_ONE  = 10'h001;
  localparam logic [CODE_W-1:0] CODE_MID  = 10'h200;
  localparam logic [CODE_W-1:0] CODE_FULL = 10'h3FF;

  // store map
  localparam logic [ADDR_W-1:0] ADDR_SAVED_CH1 = 4'h0;
  localparam logic [ADDR_W-1:0] ADDR_SAVED_CH2 = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_USER_FIRST = 4'h2;
  localparam logic [ADDR_W-1:0] ADDR_USER_LAST = 4'hE;
  localparam logic [ADDR_W-1:0] ADDR_TOLERANCE = 4'hF;

  // tolerance word fields
  localparam int unsigned TOL_SIGN_BIT = 15;
  localparam int unsigned TOL_INT_MSB  = 14;
  localparam int unsigned TOL_INT_LSB  = 8;
  localparam int unsigned TOL_FRAC_MSB = 7;
  localparam int unsigned TOL_FRAC_LSB = 0;

  // reset values: factory midscale codes, blank user words, tolerance chosen arbitrarily
  localparam logic [WORD_W-1:0] SAVED_CODE_RESET = 16'h0200;
  localparam logic [WORD_W-1:0] USER_RESET       = 16'h0000;
  localparam logic [WORD_W-1:0] TOL_RESET        = 16'h8A5C;
  localparam logic [DEPTH-1:0][WORD_W-1:0] STORE_RESET =
    {TOL_RESET, {13{USER_RESET}}, SAVED_CODE_RESET, SAVED_CODE_RESET};

  // instruction codes
  localparam logic [3:0] OP_NOP         = 4'h0;
  localparam logic [3:0] OP_RESTORE     = 4'h1;
  localparam logic [3:0] OP_SAVE_WIPER  = 4'h2;
  localparam logic [3:0] OP_STORE_USER  = 4'h3;
  localparam logic [3:0] OP_DN6         = 4'h4;
  localparam logic [3:0] OP_DN6_ALL     = 4'h5;
  localparam logic [3:0] OP_DN1         = 4'h6;
  localparam logic [3:0] OP_DN1_ALL     = 4'h7;
  localparam logic [3:0] OP_RESTORE_ALL = 4'h8;
  localparam logic [3:0] OP_READ_STORE  = 4'h9;
  localparam logic [3:0] OP_READ_WIPER  = 4'hA;
  localparam logic [3:0] OP_WRITE_WIPER = 4'hB;
  localparam logic [3:0] OP_UP6         = 4'hC;
  localparam logic [3:0] OP_UP6_ALL     = 4'hD;
  localparam logic [3:0] OP_UP1         = 4'hE;
  localparam logic [3:0] OP_UP1_ALL     = 4'hF;

  typedef struct packed {
    logic [3:0]        opcode;
    logic [ADDR_W-1:0] addr;
    logic [WORD_W-1:0] data;
  } wsn_cmd_t;

  typedef enum logic [2:0] {
    ADJ_NONE,
    ADJ_UP6,
    ADJ_DN6,
    ADJ_UP1,
    ADJ_DN1
  } wsn_adj_t;

  typedef struct packed {
    logic [DEPTH-1:0][WORD_W-1:0] store;
    logic [NCH-1:0][CODE_W-1:0]   wiper;
    logic [23:0]                  rd_word;
    logic                         rd_valid;
    logic                         read_mode;
    logic                         por_pend;
    logic [1:0]                   pr_sync;
    logic                         pr_last;
  } wsn_state_t;

endpackage : wsn_pkg

// ===== rtl/wsn_adjust.sv
// one channel's wiper code step and 6 dB shift unit
module wsn_adjust (
  input  wire logic [wsn_pkg::CODE_W-1:0] code,
  input  wsn_pkg::wsn_adj_t                op,
  output logic      [wsn_pkg::CODE_W-1:0] result
);

  always_comb begin
    unique case (op)
      wsn_pkg::ADJ_UP6: begin
        if (code == wsn_pkg::CODE_ZERO) begin
          result = wsn_pkg::CODE_ONE;
        end else if (code >= wsn_pkg::CODE_MID) begin
          result = wsn_pkg::CODE_FULL;
        end else begin
          result = {code[wsn_pkg::CODE_W-2:0], 1'b0};
        end
      end
      // truncating right shift, odd codes lose half a step
      wsn_pkg::ADJ_DN6: result = {1'b0, code[wsn_pkg::CODE_W-1:1]};
      wsn_pkg::ADJ_UP1: begin
        if (code == wsn_pkg::CODE_FULL) begin
          result = code;
        end else begin
          result = code + wsn_pkg::CODE_ONE;
        end
      end
      wsn_pkg::ADJ_DN1: begin
        if (code == wsn_pkg::CODE_ZERO) begin
          result = code;
        end else begin
          result = code - wsn_pkg::CODE_ONE;
        end
      end
      wsn_pkg::ADJ_NONE: result = code;
      default:           result = code;
    endcase
  end

endmodule : wsn_adjust

// ===== rtl/wsn_top.sv
// wiper code registers, shift commands and the nonvolatile store
module wsn_top (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           cmd_valid,
  input  wsn_pkg::wsn_cmd_t                   cmd,
  input  wire logic                           preset_pin_n,
  output logic      [wsn_pkg::CODE_W-1:0]     wiper_code_ch1,
  output logic      [wsn_pkg::CODE_W-1:0]     wiper_code_ch2,
  output logic      [23:0]                    read_word,
  output logic                                read_valid,
  output logic                                read_mode_power,
  output logic                                tol_negative,
  output logic      [6:0]                     tol_int_pct,
  output logic      [7:0]                     tol_frac_pct
);

  wsn_pkg::wsn_state_t s_q;
  wsn_pkg::wsn_state_t s_d;

  wsn_pkg::wsn_adj_t   adj_op   [wsn_pkg::NCH];
  logic [wsn_pkg::CODE_W-1:0] adj_code [wsn_pkg::NCH];

  // channel picked by address bit 0
  function automatic logic chan_of(input logic [wsn_pkg::ADDR_W-1:0] addr);
    return addr[0];
  endfunction : chan_of

  // adjustment asked of one channel by a command
  function automatic wsn_pkg::wsn_adj_t adj_of(
    input logic [3:0]                  opcode,
    input logic [wsn_pkg::ADDR_W-1:0]  addr,
    input int unsigned                 ch
  );
    logic mine;
    mine = (32'(chan_of(addr)) == ch);
    unique case (opcode)
      wsn_pkg::OP_UP6:     return mine ? wsn_pkg::ADJ_UP6 : wsn_pkg::ADJ_NONE;
      wsn_pkg::OP_UP6_ALL: return wsn_pkg::ADJ_UP6;
      wsn_pkg::OP_DN6:     return mine ? wsn_pkg::ADJ_DN6 : wsn_pkg::ADJ_NONE;
      wsn_pkg::OP_DN6_ALL: return wsn_pkg::ADJ_DN6;
      wsn_pkg::OP_UP1:     return mine ? wsn_pkg::ADJ_UP1 : wsn_pkg::ADJ_NONE;
      wsn_pkg::OP_UP1_ALL: return wsn_pkg::ADJ_UP1;
      wsn_pkg::OP_DN1:     return mine ? wsn_pkg::ADJ_DN1 : wsn_pkg::ADJ_NONE;
      wsn_pkg::OP_DN1_ALL: return wsn_pkg::ADJ_DN1;
      default:             return wsn_pkg::ADJ_NONE;
    endcase
  endfunction : adj_of

  // saved code of a channel as a 10-bit wiper value
  function automatic logic [wsn_pkg::CODE_W-1:0] saved_code(
    input wsn_pkg::wsn_state_t st,
    input int unsigned         ch
  );
    return st.store[ch][wsn_pkg::CODE_W-1:0];
  endfunction : saved_code

  generate
    for (genvar g = 0; g < wsn_pkg::NCH; g++) begin : g_ch
      always_comb begin
        adj_op[g] = adj_of(cmd.opcode, cmd.addr, g);
      end

      wsn_adjust u_adjust (
        .code   (s_q.wiper[g]),
        .op     (adj_op[g]),
        .result (adj_code[g])
      );
    end
  endgenerate

  always_comb begin
    logic pr_rise;
    logic ch;
    s_d          = s_q;
    pr_rise      = 1'b0;
    ch           = chan_of(cmd.addr);
    s_d.rd_valid = 1'b0;

    // preset pin synchroniser and release edge
    s_d.pr_sync = {s_q.pr_sync[0], preset_pin_n};
    s_d.pr_last = s_q.pr_sync[1];
    pr_rise     = s_q.pr_sync[1] & ~s_q.pr_last;

    if (cmd_valid) begin
      // command word split as instruction, address, data
      unique case (cmd.opcode)
        wsn_pkg::OP_NOP: begin
          s_d.read_mode = 1'b0;
        end
        wsn_pkg::OP_RESTORE: begin
          s_d.wiper[ch]  = saved_code(s_q, 32'(ch));
          s_d.read_mode  = 1'b1;
        end
        wsn_pkg::OP_RESTORE_ALL: begin
          for (int i = 0; i < wsn_pkg::NCH; i++) begin
            s_d.wiper[i] = saved_code(s_q, i);
          end
          s_d.read_mode = 1'b1;
        end
        wsn_pkg::OP_SAVE_WIPER: begin
          s_d.store[ch] = {6'h00, s_q.wiper[ch]};
        end
        wsn_pkg::OP_STORE_USER: begin
          if (cmd.addr != wsn_pkg::ADDR_TOLERANCE) begin
            s_d.store[cmd.addr] = cmd.data;
          end
        end
        wsn_pkg::OP_READ_STORE: begin
          s_d.rd_word  = {cmd.opcode, cmd.addr, s_q.store[cmd.addr]};
          s_d.rd_valid = 1'b1;
        end
        wsn_pkg::OP_READ_WIPER: begin
          s_d.rd_word  = {cmd.opcode, cmd.addr, 6'h00, s_q.wiper[ch]};
          s_d.rd_valid = 1'b1;
        end
        wsn_pkg::OP_WRITE_WIPER: begin
          s_d.wiper[ch] = cmd.data[wsn_pkg::CODE_W-1:0];
        end
        default: begin
          for (int i = 0; i < wsn_pkg::NCH; i++) begin
            s_d.wiper[i] = adj_code[i];
          end
        end
      endcase
    end

    // preset held low parks wipers at midscale, release reloads them
    if (!s_q.pr_sync[1]) begin
      for (int i = 0; i < wsn_pkg::NCH; i++) begin
        s_d.wiper[i] = wsn_pkg::CODE_MID;
      end
    end else if (pr_rise) begin
      for (int i = 0; i < wsn_pkg::NCH; i++) begin
        s_d.wiper[i] = saved_code(s_q, i);
      end
    end

    // power-on reload in the first cycle after reset
    if (s_q.por_pend) begin
      for (int i = 0; i < wsn_pkg::NCH; i++) begin
        s_d.wiper[i] = saved_code(s_q, i);
      end
      s_d.por_pend = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q.store     <= wsn_pkg::STORE_RESET;
      s_q.wiper     <= {wsn_pkg::NCH{wsn_pkg::CODE_MID}};
      s_q.rd_word   <= 24'h000000;
      s_q.rd_valid  <= 1'b0;
      s_q.read_mode <= 1'b0;
      s_q.por_pend  <= 1'b1;
      s_q.pr_sync   <= 2'h3;
      s_q.pr_last   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  always_comb begin
    wiper_code_ch1  = s_q.wiper[0];
    wiper_code_ch2  = s_q.wiper[1];
    read_word       = s_q.rd_word;
    read_valid      = s_q.rd_valid;
    read_mode_power = s_q.read_mode;
    // sign-magnitude tolerance fields
    tol_negative = s_q.store[wsn_pkg::ADDR_TOLERANCE][wsn_pkg::TOL_SIGN_BIT];
    tol_int_pct  = s_q.store[wsn_pkg::ADDR_TOLERANCE]
                            [wsn_pkg::TOL_INT_MSB:wsn_pkg::TOL_INT_LSB];
    tol_frac_pct = s_q.store[wsn_pkg::ADDR_TOLERANCE]
                            [wsn_pkg::TOL_FRAC_MSB:wsn_pkg::TOL_FRAC_LSB];
  end

endmodule : wsn_top

// ===== dv/wsn_host.sv
// host model issuing command words
module wsn_host (
  input  wire logic        clk,
  output logic             cmd_valid,
  output wsn_pkg::wsn_cmd_t cmd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_valid = 1'b0;
    cmd = '0;
  end
  // one 24-bit word, idle bus shows the inverse
  task automatic send(input logic [3:0] op, input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= {op, a, d};
    @(posedge clk);
    cmd_valid <= 1'b0;
    cmd <= ~{op, a, d};
  endtask : send
endmodule : wsn_host

// ===== dv/wsn_chk.sv
// assertions on the block ports
module wsn_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        cmd_valid,
  input wsn_pkg::wsn_cmd_t cmd,
  input wire logic        preset_pin_n,
  input wire logic [9:0]  wiper_code_ch1,
  input wire logic [9:0]  wiper_code_ch2,
  input wire logic [23:0] read_word,
  input wire logic        read_valid,
  input wire logic        read_mode_power,
  input wire logic        tol_negative,
  input wire logic [6:0]  tol_int_pct,
  input wire logic [7:0]  tol_frac_pct
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [2:0] hi_q;
  wire ok = hi_q == 3'h7;
  wire [3:0] op = cmd.opcode;
  wire c1 = cmd_valid && ok && !cmd.addr[0];
  wire c2 = cmd_valid && ok && cmd.addr[0];
  // cycles since preset and reset went quiet
  always_ff @(posedge clk or posedge rst)
    if (rst) hi_q <= 3'h0;
    else if (!preset_pin_n) hi_q <= 3'h0;
    else if (!ok) hi_q <= hi_q + 3'h1;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  chk_up_double: assert property (
    c1 && op == 4'hC && wiper_code_ch1 < 10'h200 |=> wiper_code_ch1 ==
    ($past(wiper_code_ch1) == 10'h0 ? 10'h1 : $past(wiper_code_ch1) << 1))
    else $error("up shift wrong");
  chk_up_sat: assert property (
    c2 && op == 4'hC && wiper_code_ch2 >= 10'h200 |=> wiper_code_ch2 == 10'h3FF)
    else $error("up shift not saturated");
  chk_dn_trunc: assert property (
    c1 && op == 4'h4 |=> wiper_code_ch1 == $past(wiper_code_ch1) >> 1)
    else $error("down shift wrong");
  chk_rd_echo: assert property (
    cmd_valid && op == 4'h9 |=> read_valid && read_word[23:16] == $past(cmd[23:16]))
    else $error("read answer wrong");
  chk_tol_read: assert property (
    cmd_valid && op == 4'h9 && cmd.addr == 4'hF
    |=> read_word[15:0] == {tol_negative, tol_int_pct, tol_frac_pct})
    else $error("tolerance read wrong");
  chk_tol_fixed: assert property (
    $stable({tol_negative, tol_int_pct, tol_frac_pct}))
    else $error("tolerance changed");
  chk_rm_set: assert property (
    cmd_valid && (op == 4'h1 || op == 4'h8) |=> read_mode_power)
    else $error("read mode not set");
  chk_rm_clear: assert property (
    cmd_valid && op == 4'h0 |=> !read_mode_power)
    else $error("read mode not cleared");
  chk_preset_mid: assert property (
    !preset_pin_n [*4] |-> wiper_code_ch1 == 10'h200 && wiper_code_ch2 == 10'h200)
    else $error("preset not midscale");
endmodule : wsn_chk
bind wsn_top wsn_chk u_wsn_chk (.clk, .rst, .cmd_valid, .cmd, .preset_pin_n,
  .wiper_code_ch1, .wiper_code_ch2, .read_word, .read_valid, .read_mode_power,
  .tol_negative, .tol_int_pct, .tol_frac_pct);

// ===== dv/testbench.sv
// self-checking bench for the wiper shift and store block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk = 1'b0;
  logic              rst = 1'b1;
  logic              preset_pin_n = 1'b1;
  logic              cv;
  wsn_pkg::wsn_cmd_t cmd;
  logic [9:0]        w1, w2, e;
  logic [23:0]       rw;
  logic              rv, rm, tn;
  logic [6:0]        ti;
  logic [7:0]        tf;
  int                n_fail = 0;
  int                compares = 0;
  always #10 clk = ~clk;
  wsn_host u_wsn_host (.clk, .cmd_valid(cv), .cmd);
  wsn_top u_wsn_top (.clk, .rst, .cmd_valid(cv), .cmd, .preset_pin_n,
    .wiper_code_ch1(w1), .wiper_code_ch2(w2), .read_word(rw), .read_valid(rv),
    .read_mode_power(rm), .tol_negative(tn), .tol_int_pct(ti), .tol_frac_pct(tf));
  task automatic chk(input string s, input logic [23:0] x, input logic [23:0] g);
    compares++;
    if (g !== x) begin
      $display("Error %s expected %h seen %h", s, x, g);
      n_fail++;
    end
  endtask : chk
  task automatic tx(input logic [3:0] op, input logic [3:0] a, input logic [15:0] d);
    u_wsn_host.send(op, a, d);
    #1;
  endtask : tx
  task automatic end_of_test;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_of_test
  initial begin
    #100000;
    n_fail++;
    end_of_test();
  end
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (8) @(posedge clk);
    #1;
    chk("reset wipers", 24'h80200, 24'({w1, w2}));
    for (int c = 0; c < 2; c++) begin
      tx(4'hB, 4'(c), 16'h0);
      e = 10'h0;
      for (int i = 0; i < 12; i++) begin
        tx(4'hC, 4'(c), 16'h0);
        e = e == 10'h0 ? 10'h1 : (e >= 10'h200 ? 10'h3FF : e << 1);
        chk("up shift", 24'(e), 24'(c ? w2 : w1));
      end
      for (int i = 0; i < 11; i++) begin
        tx(4'h4, 4'(c), 16'h0);
        e = e >> 1;
        chk("down shift", 24'(e), 24'(c ? w2 : w1));
      end
    end
    tx(4'hD, 4'h0, 16'h0);
    tx(4'hD, 4'h0, 16'h0);
    chk("gang up", 24'h802, 24'({w1, w2}));
    tx(4'h5, 4'h0, 16'h0);
    chk("gang down", 24'h401, 24'({w1, w2}));
    for (int a = 2; a < 16; a++) tx(4'h3, 4'(a), 16'hA500 | 16'(a));
    for (int a = 2; a < 16; a++) begin
      tx(4'h9, 4'(a), 16'h0);
      chk("store read", {8'h90 | 8'(a), a == 15 ? wsn_pkg::TOL_RESET : 16'hA500 | 16'(a)}, rw);
      chk("read pulse", 24'h1, 24'(rv));
    end
    @(posedge clk);
    #1;
    chk("read pulse end", 24'h0, 24'(rv));
    chk("tolerance", 24'(wsn_pkg::TOL_RESET), 24'({tn, ti, tf}));
    tx(4'hB, 4'h0, 16'h123);
    tx(4'h2, 4'h0, 16'h0);
    tx(4'hB, 4'h1, 16'h0AB);
    tx(4'h2, 4'h1, 16'h0);
    tx(4'hB, 4'h0, 16'h0);
    tx(4'h1, 4'h0, 16'h0);
    chk("restore", 24'h123, 24'(w1));
    chk("read mode", 24'h1, 24'(rm));
    tx(4'h0, 4'h0, 16'h0);
    chk("idle mode", 24'h0, 24'(rm));
    tx(4'h9, 4'h0, 16'h0);
    chk("saved ch1", 24'h900123, rw);
    tx(4'hB, 4'h0, 16'h0);
    tx(4'hB, 4'h1, 16'h0);
    tx(4'h8, 4'h0, 16'h0);
    chk("restore all", 24'h48CAB, 24'({w1, w2}));
    chk("read mode all", 24'h1, 24'(rm));
    tx(4'h0, 4'h0, 16'h0);
    @(posedge clk) preset_pin_n <= 1'b0;
    tx(4'hB, 4'h0, 16'h55);
    repeat (3) @(posedge clk);
    #1;
    chk("preset low", 24'h80200, 24'({w1, w2}));
    @(posedge clk) preset_pin_n <= 1'b1;
    repeat (6) @(posedge clk);
    #1;
    chk("preset load", 24'h48CAB, 24'({w1, w2}));
    tx(4'h9, 4'h1, 16'h0);
    chk("saved ch2", 24'h9100AB, rw);
    tx(4'hE, 4'h0, 16'h0);
    tx(4'hF, 4'h0, 16'h0);
    tx(4'h6, 4'h1, 16'h0);
    tx(4'h7, 4'h0, 16'h0);
    chk("single steps", 24'h490AA, 24'({w1, w2}));
    tx(4'hB, 4'h0, 16'h3FF);
    tx(4'hB, 4'h1, 16'h0);
    tx(4'hE, 4'h0, 16'h0);
    tx(4'h6, 4'h1, 16'h0);
    chk("step limits", 24'hFFC00, 24'({w1, w2}));
    tx(4'hA, 4'h0, 16'h0);
    chk("read wiper ch1", 24'hA003FF, rw);
    tx(4'hA, 4'h1, 16'h0);
    chk("read wiper ch2", 24'hA10000, rw);
    end_of_test();
  end
endmodule : testbench
